/* File: verilog/sart_alarm_record.v */
// serial register bank, spectral alarm settings and recording control
`timescale 1ns/1ps
`include "sart_regs.vh"
// Summary of operation
// - velocity bit 5 selects integrated velocity, else acceleration, in buffers
// - storage field bits 3:2 decides when a capture result is stored
// - mode bits 1:0 pick statistics path, spectrum path, or neither in stream mode
// - interval: 8-bit count, bits 9:8 pick seconds, minutes or hours
// - interval measured from end of one capture to start of next
// - six alarm bands, each two thresholds, chosen by the selector
// - spectral band alarms evaluated only in the two spectrum modes
// - lower band edge is a 12-bit bin number, top bits ignored
// - upper band edge is a 12-bit bin number, top bits ignored
// - band edges are bin indices, so frequency follows the decimated rate
// - warning alarm raised when in-band magnitude reaches warning level
// - critical alarm raised when in-band magnitude reaches critical level
// - in time capture mode thresholds compare against the statistics
// - thresholds share the output data encoding and compare directly
// - selector bits 9:8 are rate option, bits 2:0 band 1 to 6
// - separate six-band alarm storage for each of four rate options
// - selector write loads the window; window writes update storage only while selector band is 1 to 6
// - storage codes: 00 none, 01 on alarm, 10 after every capture

module sart_alarm_record #(
	parameter [31:0] TICKS_PER_SECOND = `SART_TICKS_PER_SECOND
) (
	input  wire        ref_clk,
	input  wire        srst,
	input  wire        spi_cs_n,
	input  wire        spi_sclk,
	input  wire        spi_mosi,
	output reg         spi_miso,
	output reg         spi_miso_oe,
	input  wire        capture_begin,
	input  wire        capture_done,
	input  wire        fft_bin_valid,
	input  wire [11:0] fft_bin_index,
	input  wire [15:0] fft_magnitude,
	input  wire        stats_valid,
	input  wire [15:0] stats_value,
	output wire        select_velocity,
	output wire [1:0]  storage_method,
	output reg         use_fft_path,
	output reg         use_stats_path,
	output wire        capture_start,
	output reg         store_record,
	output reg         warning_alarm,
	output reg         critical_alarm
);

	reg         sclk_q;
	reg         cs_q;
	reg  [3:0]  bit_cnt;
	reg  [14:0] rx_shift;
	reg  [15:0] tx_shift;
	reg  [6:0]  read_addr;
	reg         wr_stb;
	reg  [6:0]  wr_addr;
	reg  [7:0]  wr_data;

	reg  [15:0] recording_control_reg;
	reg  [15:0] capture_interval_reg;
	reg  [11:0] band_lower_bin;
	reg  [11:0] band_upper_bin;
	reg  [15:0] warning_level;
	reg  [15:0] critical_level;
	reg  [15:0] alarm_selector;
	reg         load_pending;
	reg         load_ok;

	reg  [15:0] read_word;
	reg  [15:0] next_recording_control_reg;
	reg  [15:0] next_interval;
	reg  [15:0] next_lower;
	reg  [15:0] next_upper;
	reg  [15:0] next_warning;
	reg  [15:0] next_critical;
	reg  [15:0] next_selector;

	wire [55:0] mem_rd_data;

	function wr_hit;
		input       stb;
		input [6:0] addr;
		input [6:0] reg_addr;
		begin
			wr_hit = stb && ({addr[6:1], 1'b0} == reg_addr);
		end
	endfunction

	function [15:0] merge_byte;
		input [15:0] old;
		input        high;
		input [7:0]  data;
		begin
			merge_byte = high ? {data, old[7:0]} : {old[15:8], data};
		end
	endfunction

	// rate option times six plus band minus one
	function [4:0] entry_index;
		input [15:0] sel;
		begin
			entry_index = {1'b0, sel[9:8], 2'b00} + {2'b00, sel[9:8], 1'b0}
				+ {2'b00, sel[2:0]} - 5'd1;
		end
	endfunction

	function band_valid;
		input [15:0] sel;
		begin
			band_valid = (sel[2:0] != 3'd0) && (sel[2:0] < 3'd7);
		end
	endfunction

	wire sclk_rise   = spi_sclk & ~sclk_q & ~spi_cs_n;
	wire sclk_fall   = ~spi_sclk & sclk_q & ~spi_cs_n;
	wire frame_begin = ~spi_cs_n & cs_q;

	// serial frame: bit 15 write flag, 14:8 byte address, 7:0 data
	always @(posedge ref_clk) begin
		if (srst) begin
			sclk_q      <= 1'b1;
			cs_q        <= 1'b1;
			bit_cnt     <= 4'h0;
			rx_shift    <= 15'h0000;
			tx_shift    <= 16'h0000;
			read_addr   <= 7'h00;
			wr_stb      <= 1'b0;
			wr_addr     <= 7'h00;
			wr_data     <= 8'h00;
			spi_miso    <= 1'b0;
			spi_miso_oe <= 1'b0;
		end else begin
			sclk_q      <= spi_sclk;
			cs_q        <= spi_cs_n;
			wr_stb      <= 1'b0;
			spi_miso_oe <= ~spi_cs_n;
			if (spi_cs_n) begin
				bit_cnt <= 4'h0;
			end else if (sclk_rise) begin
				bit_cnt  <= bit_cnt + 4'h1;
				rx_shift <= {rx_shift[13:0], spi_mosi};
				if (bit_cnt == 4'hF) begin
					if (rx_shift[14]) begin
						wr_stb  <= 1'b1;
						wr_addr <= rx_shift[13:7];
						wr_data <= {rx_shift[6:0], spi_mosi};
					end else begin
						read_addr <= {rx_shift[13:8], 1'b0};
					end
				end
			end
			// read data answers in the frame after the request
			if (frame_begin) begin
				tx_shift <= read_word;
				spi_miso <= read_word[15];
			end else if (sclk_fall && bit_cnt != 4'h0) begin
				tx_shift <= {tx_shift[14:0], 1'b0};
				spi_miso <= tx_shift[14];
			end
		end
	end

	always @* begin
		case (read_addr)
		`SART_RECORDING_CONTROL_REG_ADDR: read_word = recording_control_reg;
		`SART_INTERVAL_ADDR: read_word = capture_interval_reg;
		`SART_LOWER_BIN_ADDR: read_word = {4'h0, band_lower_bin};
		`SART_UPPER_BIN_ADDR: read_word = {4'h0, band_upper_bin};
		`SART_WARNING_ADDR: read_word = warning_level;
		`SART_CRITICAL_ADDR: read_word = critical_level;
		`SART_SELECTOR_ADDR: read_word = alarm_selector;
		default: read_word = 16'h0000;
		endcase
	end

	wire hit_rec  = wr_hit(wr_stb, wr_addr, `SART_RECORDING_CONTROL_REG_ADDR);
	wire hit_int  = wr_hit(wr_stb, wr_addr, `SART_INTERVAL_ADDR);
	wire hit_low  = wr_hit(wr_stb, wr_addr, `SART_LOWER_BIN_ADDR);
	wire hit_up   = wr_hit(wr_stb, wr_addr, `SART_UPPER_BIN_ADDR);
	wire hit_warn = wr_hit(wr_stb, wr_addr, `SART_WARNING_ADDR);
	wire hit_crit = wr_hit(wr_stb, wr_addr, `SART_CRITICAL_ADDR);
	wire hit_sel  = wr_hit(wr_stb, wr_addr, `SART_SELECTOR_ADDR);
	wire hit_win  = hit_low | hit_up | hit_warn | hit_crit;

	always @* begin
		next_recording_control_reg = recording_control_reg;
		next_interval = capture_interval_reg;
		next_lower    = {4'h0, band_lower_bin};
		next_upper    = {4'h0, band_upper_bin};
		next_warning  = warning_level;
		next_critical = critical_level;
		next_selector = alarm_selector;
		if (hit_rec)
			next_recording_control_reg = merge_byte(recording_control_reg, wr_addr[0],
				wr_data) & `SART_RECORDING_CONTROL_REG_MASK;
		if (hit_int)
			next_interval = merge_byte(capture_interval_reg, wr_addr[0],
				wr_data) & `SART_INTERVAL_MASK;
		if (hit_low)
			next_lower = merge_byte(next_lower, wr_addr[0], wr_data)
				& `SART_BIN_MASK;
		if (hit_up)
			next_upper = merge_byte(next_upper, wr_addr[0], wr_data)
				& `SART_BIN_MASK;
		if (hit_warn)
			next_warning = merge_byte(warning_level, wr_addr[0], wr_data);
		if (hit_crit)
			next_critical = merge_byte(critical_level, wr_addr[0], wr_data);
		if (hit_sel)
			next_selector = merge_byte(alarm_selector, wr_addr[0], wr_data)
				& `SART_SELECTOR_MASK;
	end

	// one entry per rate option and band
	sart_alarm_mem #(
		.WIDTH (56),
		.DEPTH (`SART_ALARM_ENTRIES),
		.AW    (5)
	) u_alarm_mem (
		.clk     (ref_clk),
		.srst    (srst),
		.we      (hit_win && band_valid(alarm_selector)),
		.waddr   (entry_index(alarm_selector)),
		.wdata   ({next_lower[11:0], next_upper[11:0],
			next_warning, next_critical}),
		.raddr   (entry_index(next_selector)),
		.rd_data (mem_rd_data)
	);

	always @(posedge ref_clk) begin
		if (srst) begin
			recording_control_reg <= `SART_RECORDING_CONTROL_REG_RESET;
			capture_interval_reg  <= `SART_INTERVAL_RESET;
			band_lower_bin        <= `SART_LOWER_BIN_RESET;
			band_upper_bin        <= `SART_UPPER_BIN_RESET;
			warning_level         <= `SART_WARNING_RESET;
			critical_level        <= `SART_CRITICAL_RESET;
			alarm_selector        <= `SART_SELECTOR_RESET;
			load_pending          <= 1'b0;
			load_ok               <= 1'b0;
		end else begin
			recording_control_reg <= next_recording_control_reg;
			capture_interval_reg  <= next_interval;
			alarm_selector        <= next_selector;
			load_pending          <= hit_sel;
			load_ok               <= band_valid(next_selector);
			// window follows the freshly chosen alarm
			if (load_pending) begin
				band_lower_bin <= load_ok ? mem_rd_data[55:44] : 12'h000;
				band_upper_bin <= load_ok ? mem_rd_data[43:32] : 12'h000;
				warning_level  <= load_ok ? mem_rd_data[31:16] : 16'h0000;
				critical_level <= load_ok ? mem_rd_data[15:0] : 16'h0000;
			end else begin
				band_lower_bin <= next_lower[11:0];
				band_upper_bin <= next_upper[11:0];
				warning_level  <= next_warning;
				critical_level <= next_critical;
			end
		end
	end

	wire [1:0] mode     = recording_control_reg[`SART_MODE_MSB:`SART_MODE_LSB];
	wire [1:0] next_mode = next_recording_control_reg[`SART_MODE_MSB:`SART_MODE_LSB];
	wire fft_mode = (mode == `SART_MODE_MANUAL) ||
		(mode == `SART_MODE_TIMED);

	assign select_velocity = recording_control_reg[`SART_VELOCITY_BIT];
	assign storage_method  =
		recording_control_reg[`SART_STORE_MSB:`SART_STORE_LSB];

	// bins are compared by index, so the band tracks the decimated rate
	wire in_band = (fft_bin_index >= band_lower_bin) &&
		(fft_bin_index <= band_upper_bin);
	wire fft_ok  = fft_mode && fft_bin_valid && in_band;
	wire stat_ok = (mode == `SART_MODE_TIME_CAPTURE) && stats_valid;

	// same encoding as output data, so a plain unsigned compare
	wire hit_w = (fft_ok && fft_magnitude >= warning_level) ||
		(stat_ok && stats_value >= warning_level);
	wire hit_c = (fft_ok && fft_magnitude >= critical_level) ||
		(stat_ok && stats_value >= critical_level);

	wire alarm_seen = warning_alarm | critical_alarm | hit_w | hit_c;
	wire store_on   = (storage_method == `SART_STORE_EVERY) ||
		((storage_method == `SART_STORE_ON_ALARM) && alarm_seen);

	always @(posedge ref_clk) begin
		if (srst) begin
			warning_alarm  <= 1'b0;
			critical_alarm <= 1'b0;
			store_record   <= 1'b0;
			use_fft_path   <= 1'b0;
			use_stats_path <= 1'b0;
		end else begin
			// a hit in the clearing cycle still counts
			if (capture_begin) begin
				warning_alarm  <= hit_w;
				critical_alarm <= hit_c;
			end else begin
				warning_alarm  <= warning_alarm | hit_w;
				critical_alarm <= critical_alarm | hit_c;
			end
			store_record <= capture_done && (mode != `SART_MODE_STREAM)
				&& store_on;
			use_fft_path   <= (next_mode == `SART_MODE_MANUAL) ||
				(next_mode == `SART_MODE_TIMED);
			use_stats_path <= (next_mode == `SART_MODE_TIME_CAPTURE);
		end
	end

	sart_interval_timer #(
		.TICKS_PER_SECOND (TICKS_PER_SECOND)
	) u_interval_timer (
		.clk      (ref_clk),
		.srst     (srst),
		.enable   (mode == `SART_MODE_TIMED),
		.done     (capture_done),
		.interval (capture_interval_reg[9:0]),
		.start    (capture_start)
	);

endmodule

/* File: verilog/sart_regs.vh */
// register map, field layout, reset values and timing for the alarm bank
`ifndef SART_REGS_VH
`define SART_REGS_VH

`define SART_RECORDING_CONTROL_REG_ADDR      7'h1A
`define SART_INTERVAL_ADDR      7'h1E
`define SART_LOWER_BIN_ADDR     7'h20
`define SART_UPPER_BIN_ADDR     7'h22
`define SART_WARNING_ADDR       7'h28
`define SART_CRITICAL_ADDR      7'h2E
`define SART_SELECTOR_ADDR      7'h30

`define SART_RECORDING_CONTROL_REG_RESET     16'h1102
`define SART_INTERVAL_RESET     16'h0000
`define SART_LOWER_BIN_RESET    12'h000
`define SART_UPPER_BIN_RESET    12'h000
`define SART_WARNING_RESET      16'h0000
`define SART_CRITICAL_RESET     16'h0000
`define SART_SELECTOR_RESET     16'h0000

`define SART_RECORDING_CONTROL_REG_MASK      16'hBFEF
`define SART_INTERVAL_MASK      16'h03FF
`define SART_BIN_MASK           16'h0FFF
`define SART_SELECTOR_MASK      16'h0307

`define SART_VELOCITY_BIT       5
`define SART_STORE_MSB          3
`define SART_STORE_LSB          2
`define SART_MODE_MSB           1
`define SART_MODE_LSB           0

`define SART_MODE_MANUAL        2'h0
`define SART_MODE_TIMED         2'h1
`define SART_MODE_TIME_CAPTURE  2'h2
`define SART_MODE_STREAM        2'h3

`define SART_STORE_NONE         2'h0
`define SART_STORE_ON_ALARM     2'h1
`define SART_STORE_EVERY        2'h2

`define SART_UNIT_SECONDS       2'h0
`define SART_UNIT_MINUTES       2'h1
`define SART_UNIT_HOURS         2'h2

`define SART_BANDS_PER_RATE     6
`define SART_ALARM_ENTRIES      24

`define SART_CLK_HZ             200000000
`define SART_TIME_UNIT_S        1
`define SART_TICKS_PER_SECOND   (`SART_CLK_HZ * `SART_TIME_UNIT_S)
`define SART_SECONDS_PER_MINUTE 12'd60
`define SART_SECONDS_PER_HOUR   12'd3600

`endif

/* File: verilog/sart_alarm_mem.v */
// storage for the per-rate spectral alarm band settings
`timescale 1ns/1ps

module sart_alarm_mem #(
	parameter WIDTH = 56,
	parameter DEPTH = 24,
	parameter AW    = 5
) (
	input  wire             clk,
	input  wire             srst,
	input  wire             we,
	input  wire [AW-1:0]    waddr,
	input  wire [WIDTH-1:0] wdata,
	input  wire [AW-1:0]    raddr,
	output reg  [WIDTH-1:0] rd_data
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [DEPTH-1:0] written;

	// entries never written read as zero, so no clearing sweep is needed
	always @(posedge clk) begin
		if (we)
			mem[waddr] <= wdata;
		if (srst)
			rd_data <= {WIDTH{1'b0}};
		else if (written[raddr])
			rd_data <= mem[raddr];
		else
			rd_data <= {WIDTH{1'b0}};
	end

	genvar i;
	generate
		for (i = 0; i < DEPTH; i = i + 1) begin : g_written
			always @(posedge clk) begin
				if (srst)
					written[i] <= 1'b0;
				else if (we && waddr == i)
					written[i] <= 1'b1;
			end
		end
	endgenerate

endmodule

/* File: verilog/sart_interval_timer.v */
// capture interval timer for timed spectrum mode
`timescale 1ns/1ps
`include "sart_regs.vh"

module sart_interval_timer #(
	parameter [31:0] TICKS_PER_SECOND = `SART_TICKS_PER_SECOND
) (
	input  wire       clk,
	input  wire       srst,
	input  wire       enable,
	input  wire       done,
	input  wire [9:0] interval,
	output reg        start
);

	reg        enable_q;
	reg        running;
	reg [31:0] tick_cnt;
	reg [11:0] sec_cnt;
	reg [11:0] unit_len;
	reg [7:0]  remaining;

	wire sec_end  = (tick_cnt == TICKS_PER_SECOND - 32'd1);
	wire unit_end = sec_end && (sec_cnt == unit_len - 12'd1);

	always @(posedge clk) begin
		if (srst) begin
			enable_q  <= 1'b0;
			running   <= 1'b0;
			tick_cnt  <= 32'h0000_0000;
			sec_cnt   <= 12'h000;
			unit_len  <= 12'h001;
			remaining <= 8'h00;
			start     <= 1'b0;
		end else begin
			enable_q <= enable;
			start    <= 1'b0;
			if (!enable) begin
				running <= 1'b0;
			end else if (done) begin
				// gap counts from the end of one capture
				tick_cnt  <= 32'h0000_0000;
				sec_cnt   <= 12'h000;
				remaining <= interval[7:0];
				case (interval[9:8])
				`SART_UNIT_MINUTES: unit_len <= `SART_SECONDS_PER_MINUTE;
				`SART_UNIT_HOURS:   unit_len <= `SART_SECONDS_PER_HOUR;
				default:            unit_len <= 12'd1;
				endcase
				if (interval[7:0] == 8'h00) begin
					start   <= 1'b1;
					running <= 1'b0;
				end else begin
					running <= 1'b1;
				end
			end else if (!enable_q) begin
				// first capture starts on entry to the mode
				start <= 1'b1;
			end else if (running) begin
				tick_cnt <= sec_end ? 32'h0000_0000 : tick_cnt + 32'd1;
				if (sec_end)
					sec_cnt <= unit_end ? 12'h000 : sec_cnt + 12'd1;
				if (unit_end) begin
					remaining <= remaining - 8'd1;
					if (remaining == 8'd1) begin
						start   <= 1'b1;
						running <= 1'b0;
					end
				end
			end
		end
	end

endmodule

/* File: testbench/sart_checker.sv */
// concurrent checks on the alarm bank outputs
`timescale 1ns/1ps
module sart_checker #(
	parameter [31:0] TICKS_PER_SECOND = 32'h0000000A
) (
	input wire       ref_clk,
	input wire       srst,
	input wire       capture_begin,
	input wire       capture_done,
	input wire       fft_bin_valid,
	input wire       stats_valid,
	input wire       use_fft_path,
	input wire       use_stats_path,
	input wire [1:0] storage_method,
	input wire       store_record,
	input wire       capture_start,
	input wire       warning_alarm,
	input wire       critical_alarm,
	input wire       spi_cs_n,
	input wire       spi_miso_oe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// a hit only counts on the path of the current mode
	wire hit = (fft_bin_valid && use_fft_path) ||
		(stats_valid && use_stats_path);
	sequence s_quiet_begin;
		capture_begin && !fft_bin_valid && !stats_valid;
	endsequence
	sequence s_flags_low;
		!warning_alarm && !critical_alarm;
	endsequence
	property p_one_path; !(use_fft_path && use_stats_path); endproperty
	property p_store_cause; store_record |-> $past(capture_done); endproperty
	property p_store_method;
		store_record |-> $past(storage_method) == 2'h1 ||
			$past(storage_method) == 2'h2;
	endproperty
	property p_store_pulse; store_record |=> !store_record; endproperty
	property p_warn_cause; $rose(warning_alarm) |-> $past(hit); endproperty
	property p_crit_cause; $rose(critical_alarm) |-> $past(hit); endproperty
	property p_clear; s_quiet_begin |=> s_flags_low; endproperty
	property p_sticky;
		warning_alarm && !capture_begin |=> warning_alarm;
	endproperty
	property p_start_pulse; capture_start |=> !capture_start; endproperty
	property p_oe_follow; spi_miso_oe == !$past(spi_cs_n); endproperty
	property p_start_path;
		capture_start |-> use_fft_path || $past(use_fft_path);
	endproperty
	a_one_path: assert property (p_one_path)
		else $error("both paths on");
	a_store_cause: assert property (p_store_cause)
		else $error("store without done");
	a_store_method: assert property (p_store_method)
		else $error("store with wrong method");
	a_store_pulse: assert property (p_store_pulse)
		else $error("store too long");
	a_warn_cause: assert property (p_warn_cause)
		else $error("warning without hit");
	a_crit_cause: assert property (p_crit_cause)
		else $error("critical without hit");
	a_clear: assert property (p_clear)
		else $error("flags not cleared");
	a_sticky: assert property (p_sticky)
		else $error("warning dropped");
	a_start_pulse: assert property (p_start_pulse)
		else $error("start too long");
	a_start_path: assert property (p_start_path)
		else $error("start outside spectrum mode");
	a_oe_follow: assert property (p_oe_follow)
		else $error("data out enable not following select");
endmodule
bind sart_alarm_record sart_checker #(
	.TICKS_PER_SECOND(TICKS_PER_SECOND)
) u_chk (.*);

/* File: testbench/sart_host.sv */
// host-side serial master that frames register accesses
`timescale 1ns/1ps
module sart_host (
	input  wire ref_clk,
	output reg  spi_cs_n,
	output reg  spi_sclk,
	output reg  spi_mosi,
	input  wire spi_miso
);
	initial begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b1;
		spi_mosi = 1'b0;
	end
	// three-cycle phases keep the synchronised clock edges apart
	task automatic xfer(input [15:0] w, output [15:0] r);
		integer i;
		begin
			@(posedge ref_clk) spi_cs_n <= 1'b0;
			repeat (4) @(posedge ref_clk);
			for (i = 15; i >= 0; i = i - 1) begin
				spi_sclk <= 1'b0;
				spi_mosi <= w[i];
				repeat (3) @(posedge ref_clk);
				// mode 3: take the bit at the rising edge, after the fall shifted it
				r[i] = spi_miso;
				spi_sclk <= 1'b1;
				repeat (3) @(posedge ref_clk);
			end
			spi_cs_n <= 1'b1;
			spi_mosi <= ~spi_mosi; // released line shows no stale bit
			repeat (3) @(posedge ref_clk);
		end
	endtask
endmodule

/* File: testbench/test_spectral_alarm_and_record_timer.sv */
// self-checking bench for the alarm bank and capture timer
`timescale 1ns/1ps
module test_spectral_alarm_and_record_timer;
	reg         ref_clk, srst, capture_begin, capture_done;
	reg         fft_bin_valid, stats_valid;
	reg  [11:0] fft_bin_index;
	reg  [15:0] fft_magnitude, stats_value, rd;
	wire        spi_cs_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe;
	wire        select_velocity, use_fft_path, use_stats_path;
	wire        capture_start, store_record, warning_alarm, critical_alarm;
	wire [1:0]  storage_method;
	integer     err_total, compares, cyc, stores, t_start, t0, i;
	sart_host host (.ref_clk(ref_clk), .spi_cs_n(spi_cs_n),
		.spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso));
	sart_alarm_record #(.TICKS_PER_SECOND(32'h0000000A)) dut (
		.ref_clk(ref_clk), .srst(srst), .spi_cs_n(spi_cs_n),
		.spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
		.spi_miso_oe(spi_miso_oe), .capture_begin(capture_begin),
		.capture_done(capture_done), .fft_bin_valid(fft_bin_valid),
		.fft_bin_index(fft_bin_index), .fft_magnitude(fft_magnitude),
		.stats_valid(stats_valid), .stats_value(stats_value),
		.select_velocity(select_velocity), .storage_method(storage_method),
		.use_fft_path(use_fft_path), .use_stats_path(use_stats_path),
		.capture_start(capture_start), .store_record(store_record),
		.warning_alarm(warning_alarm), .critical_alarm(critical_alarm));
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (store_record) stores <= stores + 1;
		if (capture_start) t_start <= cyc;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			close_out;
		end
	end
	task check(input [15:0] seen, input [15:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp) begin
				err_total = err_total + 1;
				$display("BAD %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task wr(input [6:0] a, input [15:0] d);
		begin
			host.xfer({1'b1, a, d[7:0]}, rd);
			host.xfer({1'b1, a + 7'h01, d[15:8]}, rd);
		end
	endtask
	task rg(input [6:0] a, input [15:0] exp);
		begin
			host.xfer({1'b0, a, 8'h00}, rd);
			host.xfer(16'h0000, rd);
			check(rd, exp);
		end
	endtask
	task pls(input b);
		begin
			@(posedge ref_clk);
			if (b) capture_begin <= 1'b1;
			else capture_done <= 1'b1;
			@(posedge ref_clk);
			capture_begin <= 1'b0;
			capture_done <= 1'b0;
			repeat (3) @(posedge ref_clk);
		end
	endtask
	task hit(input f, input [11:0] b, input [15:0] m, input [15:0] exp);
		begin
			@(posedge ref_clk);
			fft_bin_valid <= f;
			stats_valid <= ~f;
			fft_bin_index <= b;
			fft_magnitude <= m;
			stats_value <= m;
			@(posedge ref_clk);
			fft_bin_valid <= 1'b0;
			stats_valid <= 1'b0;
			repeat (3) @(posedge ref_clk);
			check({14'h0000, critical_alarm, warning_alarm}, exp);
		end
	endtask
	task close_out;
		begin
			$display("compares %0d err_total %0d", compares, err_total);
			if (err_total == 0 && compares > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	initial begin
		{srst, capture_begin, capture_done, fft_bin_valid} = 4'h8;
		{stats_valid, fft_bin_index, fft_magnitude, stats_value} = 0;
		{err_total, compares, cyc, stores, t_start} = 0;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check({14'h0000, use_stats_path, use_fft_path}, 16'h0002);
		rg(7'h1A, 16'h1102);
		rg(7'h1E, 16'h0000);
		rg(7'h30, 16'h0000);
		rg(7'h10, 16'h0000);
		$display("reset test done");
		for (i = 0; i < 4; i = i + 1) begin
			wr(7'h1A, {8'h11, 2'h0, i[0], 1'b0, i[1:0], i[1:0]});
			check({15'h0000, select_velocity}, {15'h0000, i[0]});
			check({14'h0000, storage_method}, {14'h0000, i[1:0]});
			check({15'h0000, use_fft_path}, i < 2);
			check({15'h0000, use_stats_path}, i == 2);
		end
		$display("mode test done");
		wr(7'h30, 16'hFEFB);
		rg(7'h30, 16'h0203);
		wr(7'h20, 16'hF064);
		wr(7'h22, 16'hF0C8);
		wr(7'h28, 16'h1000);
		wr(7'h2E, 16'h2000);
		wr(7'h30, 16'h0306);
		wr(7'h20, 16'h0007);
		wr(7'h30, 16'h0003);
		rg(7'h20, 16'h0000);
		wr(7'h30, 16'h0306);
		rg(7'h20, 16'h0007);
		wr(7'h30, 16'h0203);
		rg(7'h20, 16'h0064);
		rg(7'h22, 16'h00C8);
		rg(7'h28, 16'h1000);
		rg(7'h2E, 16'h2000);
		$display("selector test done");
		wr(7'h1A, 16'h1104);
		rg(7'h1A, 16'h1104);
		pls(1'b1);
		hit(1'b1, 12'h063, 16'hFFFF, 16'h0000);
		hit(1'b1, 12'h064, 16'h1000, 16'h0001);
		hit(1'b1, 12'h0C8, 16'h2000, 16'h0003);
		pls(1'b0);
		check(stores, 16'h0001);
		wr(7'h1A, 16'h110A);
		pls(1'b1);
		hit(1'b1, 12'h064, 16'hFFFF, 16'h0000);
		hit(1'b0, 12'h000, 16'h1FFF, 16'h0001);
		pls(1'b0);
		check(stores, 16'h0002);
		wr(7'h1A, 16'h1100);
		pls(1'b1);
		hit(1'b1, 12'h080, 16'h3000, 16'h0003);
		pls(1'b0);
		check(stores, 16'h0002);
		$display("alarm test done");
		wr(7'h1E, 16'hFC02);
		rg(7'h1E, 16'h0002);
		wr(7'h1A, 16'h1101);
		t0 = cyc;
		pls(1'b0);
		repeat (40) @(posedge ref_clk);
		check(t_start - t0 >= 20 && t_start - t0 <= 24, 16'h0001);
		wr(7'h1E, 16'h0101);
		t0 = cyc;
		pls(1'b0);
		repeat (640) @(posedge ref_clk);
		check(t_start - t0 >= 600 && t_start - t0 <= 604, 16'h0001);
		$display("timer test done");
		close_out;
	end
endmodule
